// ### src/arb_top.sv
`timescale 1ns/1ps
// Functional notes
// - the samples-per-interrupt point sets the interrupt flag, and the irq rises when unmasked.
// - with scan enabled, the scan list restarts from its first entry at that point.
// - without result DMA the result pointer returns to buffer 0 at that point.
// - with result DMA only buffer 0 is used and the DMA address steps after conversions.
// - in DMA mode the DMA address advances after every 32nd completed conversion.
// - without DMA sixteen buffers fill in sequence whatever input was converted.
// - the done flag clears at conversion start or on a control write with bit 15 clear, and sets at completion.
// - the DMA enable bit 8 selects buffer 0 only or buffers 0 through 15.
// - the 3-bit buffer length code gives 1 to 128 words per input as a power of two.
// - the negative selects (bit 15 set B, bit 7 set A) pick input 1 or the low reference.
// - the set B positive select decodes inputs 0-15, op-amps, temp diode and open.
// - the set A positive select sits in bits 4-0 with the same codes as set B.
// - op-amp codes route the op-amp output when enabled, else the shared pin.
module arb_top
	import arb_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic conv_start,
	input wire logic conv_done,
	input wire logic [RES_W-1:0] conv_result,
	input wire logic use_set_b,
	input wire logic [2:0] opamp_enable,
	input wire logic dma_ack,
	output logic irq,
	output logic scan_restart,
	output logic dma_req,
	output logic dma_addr_advance,
	output logic [7:0] dma_buffer_words,
	output logic [DATA_W-1:0] dma_data,
	output arb_route_t pos_route,
	output logic [3:0] pos_pin,
	output logic [1:0] pos_opamp,
	output logic neg_is_pin,
	output logic [3:0] neg_pin
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic dma_en;
		logic [DMA_BUFFER_LENGTH_W-1:0] dma_buffer_length;
		logic neg_b;
		logic [SEL_W-1:0] pos_b;
		logic neg_a;
		logic [SEL_W-1:0] pos_a;
		logic [SAMPLES_PER_INTERRUPT_W-1:0] samples_per_interrupt;
		logic scan_en;
		logic done;
		logic [ST_W-1:0] status;
		logic [ST_W-1:0] mask;
		logic [PTR_W-1:0] ptr;
		logic [SAMPLES_PER_INTERRUPT_W-1:0] smp_cnt;
		logic [4:0] dma_cnt;
		logic buf0_unread;
		logic [NUM_BUFS-1:0][DATA_W-1:0] bufs;
		logic [DATA_W-1:0] rdata;
		logic scan_restart;
		logic dma_req;
		logic dma_adv;
	} arb_state_t;

	arb_state_t st_r;
	arb_state_t st_nxt;
	logic [SEL_W-1:0] pos_code;
	logic [PTR_W-1:0] wr_ptr;
	logic samples_per_interrupt_hit;
	logic [ST_W-1:0] st_evt;
	logic [DATA_W-1:0] result_word;

	assign result_word = {{(DATA_W-RES_W){1'b0}}, conv_result};
	assign wr_ptr = st_r.dma_en ? {PTR_W{1'b0}} : st_r.ptr;
	assign samples_per_interrupt_hit = conv_done && (st_r.smp_cnt == st_r.samples_per_interrupt);
	assign pos_code = use_set_b ? st_r.pos_b : st_r.pos_a;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.scan_restart = 1'b0;
		st_nxt.dma_req = 1'b0;
		st_nxt.dma_adv = 1'b0;
		st_nxt.rdata = RST_WORD;
		st_evt = '0;

		// register writes
		if (reg_wr) begin
			if (reg_addr == OFF_DMA_CONFIG) begin
				st_nxt.dma_en = reg_wdata[DMA_EN_BIT];
				st_nxt.dma_buffer_length = reg_wdata[DMA_BUFFER_LENGTH_LSB +: DMA_BUFFER_LENGTH_W];
			end else if (reg_addr == OFF_CH0_SELECT) begin
				st_nxt.neg_b = reg_wdata[NEG_B_BIT];
				st_nxt.pos_b = reg_wdata[POS_B_LSB +: SEL_W];
				st_nxt.neg_a = reg_wdata[NEG_A_BIT];
				st_nxt.pos_a = reg_wdata[POS_A_LSB +: SEL_W];
			end else if (reg_addr == OFF_CONTROL) begin
				st_nxt.samples_per_interrupt = reg_wdata[SAMPLES_PER_INTERRUPT_LSB +: SAMPLES_PER_INTERRUPT_W];
				st_nxt.scan_en = reg_wdata[SCAN_EN_BIT];
				// software may clear done only
				if (!reg_wdata[DONE_BIT]) begin
					st_nxt.done = 1'b0;
				end
			end else if (reg_addr == OFF_STATUS) begin
				st_nxt.status = st_r.status & ~reg_wdata[ST_W-1:0];
			end else if (reg_addr == OFF_MASK) begin
				st_nxt.mask = reg_wdata[ST_W-1:0];
			end
		end

		// reading buffer 0 frees it for the next result
		if (dma_ack || (reg_rd && reg_addr == OFF_BUF_BASE)) begin
			st_nxt.buf0_unread = 1'b0;
		end

		// conversion start and done
		if (conv_start) begin
			st_nxt.done = 1'b0;
		end
		if (conv_done) begin
			st_nxt.done = 1'b1;
			st_evt[ST_CONV] = 1'b1;
			st_nxt.bufs[wr_ptr] = result_word;
			if (st_r.dma_en) begin
				// unread result lost to the new one
				if (st_r.buf0_unread && !dma_ack) begin
					st_evt[ST_OVERRUN] = 1'b1;
				end
				st_nxt.buf0_unread = 1'b1;
				st_nxt.dma_req = 1'b1;
				st_nxt.ptr = {PTR_W{1'b0}};
				st_nxt.dma_cnt = st_r.dma_cnt + 5'h01;
				if (st_r.dma_cnt == DMA_ADV_LAST) begin
					st_nxt.dma_adv = 1'b1;
				end
			end else begin
				st_nxt.ptr = st_r.ptr + 4'h1;
			end
			st_nxt.smp_cnt = st_r.smp_cnt + 5'h01;
			if (samples_per_interrupt_hit) begin
				st_nxt.smp_cnt = '0;
				st_evt[ST_SAMPLES_PER_INTERRUPT] = 1'b1;
				st_nxt.scan_restart = st_r.scan_en;
				if (!st_r.dma_en) begin
					st_nxt.ptr = {PTR_W{1'b0}};
				end
			end
		end
		// events win over a same-cycle clear
		st_nxt.status = st_nxt.status | st_evt;

		// register reads, answered next cycle
		if (reg_rd) begin
			if (reg_addr == OFF_DMA_CONFIG) begin
				st_nxt.rdata[DMA_EN_BIT] = st_r.dma_en;
				st_nxt.rdata[DMA_BUFFER_LENGTH_LSB +: DMA_BUFFER_LENGTH_W] = st_r.dma_buffer_length;
			end else if (reg_addr == OFF_CH0_SELECT) begin
				st_nxt.rdata[NEG_B_BIT] = st_r.neg_b;
				st_nxt.rdata[POS_B_LSB +: SEL_W] = st_r.pos_b;
				st_nxt.rdata[NEG_A_BIT] = st_r.neg_a;
				st_nxt.rdata[POS_A_LSB +: SEL_W] = st_r.pos_a;
			end else if (reg_addr == OFF_CONTROL) begin
				st_nxt.rdata[SAMPLES_PER_INTERRUPT_LSB +: SAMPLES_PER_INTERRUPT_W] = st_r.samples_per_interrupt;
				st_nxt.rdata[SCAN_EN_BIT] = st_r.scan_en;
				st_nxt.rdata[DONE_BIT] = st_r.done;
			end else if (reg_addr == OFF_STATUS) begin
				st_nxt.rdata[ST_W-1:0] = st_r.status;
			end else if (reg_addr == OFF_MASK) begin
				st_nxt.rdata[ST_W-1:0] = st_r.mask;
			end else if (reg_addr == OFF_POINTER) begin
				st_nxt.rdata[PTR_W-1:0] = st_r.ptr;
			end else if (reg_addr[ADDR_W-1]) begin
				st_nxt.rdata = st_r.bufs[reg_addr[PTR_W-1:0]];
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// positive input decode
	// ----------------------------------------
	arb_pos_decode u_pos_decode (
		.code(pos_code),
		.opamp_enable(opamp_enable),
		.route(pos_route),
		.pin(pos_pin),
		.opamp_index(pos_opamp)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata = st_r.rdata;
	assign irq = |(st_r.status & st_r.mask);
	assign scan_restart = st_r.scan_restart;
	assign dma_req = st_r.dma_req;
	assign dma_addr_advance = st_r.dma_adv;
	assign dma_data = st_r.bufs[0];
	assign dma_buffer_words = 8'h01 << st_r.dma_buffer_length;
	assign neg_is_pin = use_set_b ? st_r.neg_b : st_r.neg_a;
	assign neg_pin = NEG_INPUT_PIN;
endmodule : arb_top

// ### shared/arb_pkg.sv
package arb_pkg;
	// ----------------------------------------
	// register bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int RES_W = 12;
	localparam logic [ADDR_W-1:0] OFF_DMA_CONFIG = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_CH0_SELECT = 5'h01;
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 5'h02;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h03;
	localparam logic [ADDR_W-1:0] OFF_MASK = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_POINTER = 5'h05;
	localparam logic [ADDR_W-1:0] OFF_BUF_BASE = 5'h10;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int DMA_EN_BIT = 8;
	localparam int DMA_BUFFER_LENGTH_LSB = 0;
	localparam int DMA_BUFFER_LENGTH_W = 3;
	localparam int NEG_B_BIT = 15;
	localparam int POS_B_LSB = 8;
	localparam int NEG_A_BIT = 7;
	localparam int POS_A_LSB = 0;
	localparam int SEL_W = 5;
	localparam int SAMPLES_PER_INTERRUPT_LSB = 0;
	localparam int SAMPLES_PER_INTERRUPT_W = 5;
	localparam int SCAN_EN_BIT = 8;
	localparam int DONE_BIT = 15;
	localparam int ST_SAMPLES_PER_INTERRUPT = 0;
	localparam int ST_OVERRUN = 1;
	localparam int ST_CONV = 2;
	localparam int ST_W = 3;
	localparam int NUM_BUFS = 16;
	localparam int PTR_W = 4;
	// ----------------------------------------
	// reset values and counts
	// ----------------------------------------
	localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
	localparam logic [4:0] DMA_ADV_LAST = 5'h1f;
	// ----------------------------------------
	// positive select codes
	// ----------------------------------------
	localparam logic [SEL_W-1:0] CODE_AIN_LAST = 5'h0f;
	localparam logic [SEL_W-1:0] CODE_OPAMP1 = 5'h18;
	localparam logic [SEL_W-1:0] CODE_OPAMP2 = 5'h19;
	localparam logic [SEL_W-1:0] CODE_OPAMP3 = 5'h1a;
	localparam logic [SEL_W-1:0] CODE_TEMP = 5'h1e;
	localparam logic [SEL_W-1:0] CODE_OPEN = 5'h1f;
	localparam logic [3:0] OPAMP1_SHARED_PIN = 4'h3;
	localparam logic [3:0] OPAMP2_SHARED_PIN = 4'h0;
	localparam logic [3:0] OPAMP3_SHARED_PIN = 4'h6;
	localparam logic [3:0] NEG_INPUT_PIN = 4'h1;

	typedef enum logic [2:0] {
		ARB_ROUTE_PIN = 3'b000,
		ARB_ROUTE_OPAMP = 3'b001,
		ARB_ROUTE_TEMP = 3'b010,
		ARB_ROUTE_OPEN = 3'b011,
		ARB_ROUTE_RSVD = 3'b100
	} arb_route_t;
endpackage : arb_pkg

// ### src/arb_pos_decode.sv
`timescale 1ns/1ps
module arb_pos_decode
	import arb_pkg::*;
(
	input wire logic [SEL_W-1:0] code,
	input wire logic [2:0] opamp_enable,
	output arb_route_t route,
	output logic [3:0] pin,
	output logic [1:0] opamp_index
);
	// ----------------------------------------
	// code to analog route
	// ----------------------------------------
	always_comb begin
		route = ARB_ROUTE_RSVD;
		pin = 4'h0;
		opamp_index = 2'h0;
		if (code <= CODE_AIN_LAST) begin
			route = ARB_ROUTE_PIN;
			pin = code[3:0];
		end else if (code == CODE_OPAMP1) begin
			pin = OPAMP1_SHARED_PIN;
			opamp_index = 2'h0;
			route = opamp_enable[0] ? ARB_ROUTE_OPAMP : ARB_ROUTE_PIN;
		end else if (code == CODE_OPAMP2) begin
			pin = OPAMP2_SHARED_PIN;
			opamp_index = 2'h1;
			route = opamp_enable[1] ? ARB_ROUTE_OPAMP : ARB_ROUTE_PIN;
		end else if (code == CODE_OPAMP3) begin
			pin = OPAMP3_SHARED_PIN;
			opamp_index = 2'h2;
			route = opamp_enable[2] ? ARB_ROUTE_OPAMP : ARB_ROUTE_PIN;
		end else if (code == CODE_TEMP) begin
			route = ARB_ROUTE_TEMP;
		end else if (code == CODE_OPEN) begin
			route = ARB_ROUTE_OPEN;
		end
	end
endmodule : arb_pos_decode

// ### tb/arb_top_asserts.sv
`timescale 1ns/1ps
module arb_top_asserts
	import arb_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic conv_done,
	input wire logic [2:0] opamp_enable,
	input wire logic scan_restart,
	input wire logic dma_req,
	input wire logic dma_addr_advance,
	input wire logic [7:0] dma_buffer_words,
	input wire arb_route_t pos_route,
	input wire logic [1:0] pos_opamp,
	input wire logic [3:0] neg_pin
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	a_words_power_two: assert property ($onehot(dma_buffer_words))
		else $error("buffer length not a power of two");
	a_neg_pin_fixed: assert property (neg_pin == NEG_INPUT_PIN)
		else $error("negative pin index wrong");
	a_req_after_done: assert property (dma_req |-> $past(conv_done))
		else $error("dma request without completion");
	a_scan_after_done: assert property ($rose(scan_restart) |-> $past(conv_done))
		else $error("scan restart without completion");
	a_adv_after_done: assert property (dma_addr_advance |-> $past(conv_done))
		else $error("address advance without completion");
	a_adv_spacing: assert property (dma_addr_advance |=> !dma_addr_advance [*8])
		else $error("address advance too soon");
	a_opamp_enabled: assert property (pos_route == ARB_ROUTE_OPAMP |-> opamp_enable[pos_opamp])
		else $error("op-amp routed while disabled");
endmodule : arb_top_asserts

bind arb_top arb_top_asserts i_arb_top_asserts (.clk(clk), .rstn(rstn), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .conv_done(conv_done), .opamp_enable(opamp_enable),
	.scan_restart(scan_restart), .dma_req(dma_req), .dma_addr_advance(dma_addr_advance),
	.dma_buffer_words(dma_buffer_words), .pos_route(pos_route), .pos_opamp(pos_opamp),
	.neg_pin(neg_pin));

// ### tb/arb_dma_reader.sv
`timescale 1ns/1ps
module arb_dma_reader (
	input wire logic clk,
	input wire logic rstn,
	input wire logic dma_req,
	input wire logic hold,
	output logic dma_ack
);
	// takes buffer 0 one cycle after each request, never while stalled
	always_ff @(posedge clk) begin
		dma_ack <= rstn && dma_req && !hold;
	end
endmodule : arb_dma_reader

// ### tb/test_arb_top.sv
`timescale 1ns/1ps
module test_arb_top;
	import arb_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, conv_start = 1'b0;
	logic conv_done = 1'b0, use_set_b = 1'b0, hold = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, dma_data;
	logic [RES_W-1:0] conv_result = '0;
	logic [2:0] opamp_enable = 3'h0;
	logic irq, scan_restart, dma_req, dma_addr_advance, neg_is_pin, dma_ack;
	logic [7:0] dma_buffer_words;
	arb_route_t pos_route;
	logic [3:0] pos_pin, neg_pin;
	logic [1:0] pos_opamp;
	int num_errors = 0, check_count = 0, scans = 0, advs = 0;
	arb_top i_arb_top (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
		.conv_done(conv_done), .conv_result(conv_result), .use_set_b(use_set_b),
		.opamp_enable(opamp_enable), .dma_ack(dma_ack), .irq(irq),
		.scan_restart(scan_restart), .dma_req(dma_req), .dma_addr_advance(dma_addr_advance),
		.dma_buffer_words(dma_buffer_words), .dma_data(dma_data), .pos_route(pos_route),
		.pos_pin(pos_pin), .pos_opamp(pos_opamp), .neg_is_pin(neg_is_pin), .neg_pin(neg_pin));
	arb_dma_reader i_arb_dma_reader (.clk(clk), .rstn(rstn), .dma_req(dma_req), .hold(hold),
		.dma_ack(dma_ack));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (scan_restart === 1'b1) scans++;
		if (dma_addr_advance === 1'b1) advs++;
	end
	task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check("reg_rdata", reg_rdata, e);
	endtask : rd
	task automatic conv(input logic [11:0] r);
		@(posedge clk);
		conv_start <= 1'b1;
		@(posedge clk);
		conv_start <= 1'b0; conv_done <= 1'b1; conv_result <= r;
		@(posedge clk);
		conv_done <= 1'b0;
		@(posedge clk);
		#1;
	endtask : conv
	task automatic sel(input logic [4:0] c, input logic [2:0] en, input arb_route_t ro,
		input logic [3:0] p);
		opamp_enable <= en;
		for (int b = 0; b < 2; b++) begin
			wr(5'h01, b ? {1'b1, 2'b00, c, 8'h1f} : {8'h1f, 1'b1, 2'b00, c});
			use_set_b <= b[0];
			@(posedge clk);
			#1 check("pos_route", 16'(pos_route), 16'(ro));
			check("neg_is_pin", 16'(neg_is_pin), 16'h1);
			if (ro == ARB_ROUTE_PIN) check("pos_pin", 16'(pos_pin), 16'(p));
			if (ro == ARB_ROUTE_OPAMP) check("pos_opamp", 16'(pos_opamp), 16'(p));
		end
	endtask : sel
	task automatic t_regs();
		for (int a = 0; a < 5; a++) rd(5'(a), 16'h0000);
		wr(5'h00, 16'hffff);
		rd(5'h00, 16'h0107);
		wr(5'h01, 16'hffff);
		rd(5'h01, 16'h9f9f);
		rd(5'h08, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			wr(5'h00, 16'(i));
			#1 check("dma_buffer_words", 16'(dma_buffer_words), 16'(1 << i));
		end
		wr(5'h00, 16'h0000);
	endtask : t_regs
	task automatic t_sel();
		sel(5'h00, 3'h0, ARB_ROUTE_PIN, 4'h0);
		sel(5'h0f, 3'h0, ARB_ROUTE_PIN, 4'hf);
		sel(5'h18, 3'h0, ARB_ROUTE_PIN, 4'h3);
		sel(5'h18, 3'h1, ARB_ROUTE_OPAMP, 4'h0);
		sel(5'h19, 3'h2, ARB_ROUTE_OPAMP, 4'h1);
		sel(5'h19, 3'h5, ARB_ROUTE_PIN, 4'h0);
		sel(5'h1a, 3'h4, ARB_ROUTE_OPAMP, 4'h2);
		sel(5'h1a, 3'h3, ARB_ROUTE_PIN, 4'h6);
		sel(5'h1e, 3'h0, ARB_ROUTE_TEMP, 4'h0);
		sel(5'h1f, 3'h0, ARB_ROUTE_OPEN, 4'h0);
		sel(5'h10, 3'h0, ARB_ROUTE_RSVD, 4'h0);
		sel(5'h1b, 3'h0, ARB_ROUTE_RSVD, 4'h0);
		wr(5'h01, 16'h0000);
		#1 check("neg_is_pin", 16'(neg_is_pin), 16'h0);
	endtask : t_sel
	task automatic t_seq();
		wr(5'h02, 16'h0101);
		wr(5'h04, 16'h0001);
		scans = 0;
		conv(12'h111);
		check("irq", 16'(irq), 16'h0);
		rd(5'h05, 16'h0001);
		conv(12'h222);
		check("irq", 16'(irq), 16'h1);
		check("scans", 16'(scans), 16'h1);
		rd(5'h10, 16'h0111);
		rd(5'h11, 16'h0222);
		rd(5'h05, 16'h0000);
		conv(12'h333);
		rd(5'h10, 16'h0333);
		rd(5'h03, 16'h0005);
		wr(5'h03, 16'h0005);
		#1 check("irq", 16'(irq), 16'h0);
		repeat (5) @(posedge clk);
		rd(5'h02, 16'h8101);
		@(posedge clk);
		conv_start <= 1'b1;
		@(posedge clk);
		conv_start <= 1'b0;
		rd(5'h02, 16'h0101);
		conv(12'h444);
		rd(5'h02, 16'h8101);
		wr(5'h02, 16'h8101);
		rd(5'h02, 16'h8101);
		wr(5'h02, 16'h0101);
		rd(5'h02, 16'h0101);
	endtask : t_seq
	task automatic t_dma();
		@(posedge clk);
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		wr(5'h00, 16'h0100);
		advs = 0;
		scans = 0;
		for (int i = 0; i < 31; i++) conv(12'(i));
		check("advs", 16'(advs), 16'h0);
		conv(12'habc);
		check("advs", 16'(advs), 16'h1);
		check("dma_data", dma_data, 16'h0abc);
		rd(5'h11, 16'h0000);
		rd(5'h03, 16'h0005);
		hold <= 1'b1;
		conv(12'h001);
		conv(12'h002);
		rd(5'h03, 16'h0007);
		check("scans", 16'(scans), 16'h0);
	endtask : t_dma
	task automatic give_verdict();
		if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_sel();
		t_seq();
		t_dma();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		give_verdict();
	end
endmodule : test_arb_top
